// >>> bench/siu_core_model.sv
// partner: core side that acknowledges entries and keeps the mask
`timescale 1ns/1ps
`default_nettype none
module siu_core_model #(
   parameter int ACK_DELAY = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire siu_pkg::siu_entry_t entry,
   input wire logic mask_set,
   input wire logic mask_clr,
   input wire logic rti_exec,
   output logic vector_fetch,
   output logic global_mask
);
   import siu_pkg::*;
   int wait_q;
   logic saved_q;
   // wait a while on a pending entry, then fetch its vector once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 0;
         vector_fetch <= 1'b0;
      end else if (entry.valid && !vector_fetch && wait_q < ACK_DELAY) begin
         wait_q <= wait_q + 1;
      end else begin
         wait_q <= 0;
         vector_fetch <= entry.valid && !vector_fetch;
      end
   end
   // entry sets the mask, return restores it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_mask <= 1'b1;
         saved_q <= 1'b1;
      end else if (vector_fetch && entry.set_imask) begin
         saved_q <= global_mask;
         global_mask <= 1'b1;
      end else if (rti_exec) begin
         global_mask <= saved_q;
      end else if (mask_set || mask_clr) begin
         global_mask <= mask_set;
      end
   end
endmodule
`default_nettype wire

// >>> bench/siu_props.sv
// checker: entry, stop and status relations at the unit's ports
`timescale 1ns/1ps
`default_nettype none
module siu_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire siu_pkg::siu_apb_req_t apb_req,
   input wire siu_pkg::siu_apb_rsp_t apb_rsp,
   input wire logic ext_reset_pin_n,
   input wire logic internal_reset,
   input wire logic stop_exec,
   input wire logic instr_boundary,
   input wire logic global_mask,
   input wire logic swi_exec,
   input wire logic vector_fetch,
   input wire logic [10:0] irq_req,
   input wire logic [10:0] irq_en,
   input wire logic break_req,
   input wire siu_pkg::siu_entry_t entry,
   input wire logic bus_clk_enable
);
   import siu_pkg::*;
   logic [2:0] pin_q;
   logic [3:0] pick_q;
   logic quiet;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================
   // helpers
   // pin history, lowest enabled level
   always_ff @(posedge pclk) begin
      pin_q <= {pin_q[1:0], ext_reset_pin_n};
      pick_q <= 4'h0;
      for (int i = 10; i >= 0; i--) begin
         if (irq_req[i] && irq_en[i]) begin
            pick_q <= 4'(i + 1);
         end
      end
   end
   assign quiet = &pin_q && ext_reset_pin_n && !internal_reset;
   sequence idle_take;
      instr_boundary && quiet && bus_clk_enable && !entry.valid;
   endsequence
   sequence hw_take;
      idle_take ##0 (!swi_exec && !break_req && !global_mask && |(irq_req & irq_en));
   endsequence
   // =====================================================
   // assertions
   prio_pick_a: assert property (
      hw_take |=> entry.valid && entry.code == pick_q && entry.pc_minus_one && entry.set_imask)
      else $error("wrong hardware entry");
   mask_gate_a: assert property (
      idle_take ##0 (!swi_exec && !break_req && (global_mask || !(|(irq_req & irq_en))))
      |=> !entry.valid) else $error("entry taken while masked");
   trap_take_a: assert property (
      idle_take ##0 (swi_exec || break_req) |=> entry.valid && entry.code == SIU_CODE_SWI
      && !entry.pc_minus_one) else $error("trap entry wrong");
   latch_hold_a: assert property (
      entry.valid && !vector_fetch && quiet && (entry.code == SIU_CODE_SWI
      || !(global_mask || $past(global_mask) || $past(global_mask, 2)))
      |=> entry.valid && $stable(entry.code)) else $error("latched entry displaced");
   fetch_drop_a: assert property (
      vector_fetch && entry.valid && quiet |=> !entry.valid) else $error("entry kept after fetch");
   stop_gate_a: assert property (
      stop_exec && bus_clk_enable && quiet |=> !bus_clk_enable) else $error("stop not entered");
   recover_hold_a: assert property (
      !bus_clk_enable && !entry.valid && quiet |=> !entry.valid) else $error("entry in recovery");
   pend_read_a: assert property (
      apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == SIU_ADDR_PEND_LOW
      && $stable(irq_req) |-> apb_rsp.prdata == {24'h0, irq_req[5:0], 2'b00})
      else $error("pending low read wrong");
   index_high_a: assert property (
      entry.valid |-> !entry.push_index_high) else $error("index high stacked");
endmodule
bind siu_top siu_props siu_props_i (.pclk, .presetn, .apb_req, .apb_rsp, .ext_reset_pin_n,
   .internal_reset, .stop_exec, .instr_boundary, .global_mask, .swi_exec, .vector_fetch,
   .irq_req, .irq_en, .break_req, .entry, .bus_clk_enable);
`default_nettype wire

// >>> bench/siu_top_bench.sv
// testbench: entries, status reads, break protection, stop recovery
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module siu_top_bench;
   import siu_pkg::*;
   typedef struct packed {
      logic [10:0] r;
      logic [10:0] e;
      logic [3:0] sbmv;
      logic [3:0] c;
      logic p;
   } siu_row_t;
   logic pclk = 1'b0, presetn = 1'b0, osc_crystal_clk = 1'b0, ext_reset_pin_n = 1'b1;
   logic short_stop_recovery = 1'b0, stop_exec = 1'b0, instr_boundary = 1'b0;
   logic swi_exec = 1'b0, break_req = 1'b0, break_exit = 1'b0, mask_set = 1'b0;
   logic mask_clr = 1'b0, vector_fetch, global_mask, bus_clk_enable, in_break;
   logic flag_clear_allow, rd_err;
   logic [10:0] irq_req = '0, irq_en = '0;
   logic [31:0] rd_data, cnt_before;
   siu_apb_req_t apb_req = '0;
   siu_apb_rsp_t apb_rsp;
   siu_entry_t entry;
   int err_total = 0, checks = 0;
   siu_row_t rows [7] = '{{11'h004, 11'h7ff, 4'b0001, 4'h3, 1'b1},
      {11'h7fe, 11'h7ff, 4'b0001, 4'h2, 1'b1}, {11'h003, 11'h7fe, 4'b0001, 4'h2, 1'b1},
      {11'h001, 11'h7ff, 4'b0010, 4'h0, 1'b0}, {11'h000, 11'h000, 4'b1011, 4'h0, 1'b0},
      {11'h001, 11'h7ff, 4'b1001, 4'h0, 1'b0}, {11'h000, 11'h000, 4'b0101, 4'h0, 1'b0}};
   siu_top siu_top_i (.pclk, .presetn, .apb_req, .apb_rsp, .osc_crystal_clk, .ext_reset_pin_n,
      .internal_reset(1'b0), .short_stop_recovery, .stop_exec, .instr_boundary, .global_mask,
      .swi_exec, .rti_exec(1'b0), .vector_fetch, .irq_req, .irq_en, .break_req, .break_exit,
      .entry, .bus_clk_enable, .watchdog_clk(), .in_break, .flag_clear_allow);
   siu_core_model siu_core_model_i (.pclk, .presetn, .entry, .mask_set, .mask_clr,
      .rti_exec(1'b0), .vector_fetch, .global_mask);
   // clocks: 200 MHz bus side, slower oscillator
   initial begin
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      forever #10 osc_crystal_clk = ~osc_crystal_clk;
   end
   task automatic wrap_up();
      if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      rd_data = apb_rsp.prdata;
      rd_err = apb_rsp.pslverr;
      apb_req <= '0;
      #1;
      if (n >= 20) begin
         err_total++;
         wrap_up();
      end
   endtask
   // wait for the core to fetch, then drop the requests
   task automatic settle();
      int n = 0;
      while (entry.valid !== 1'b0 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 50) begin
         err_total++;
         wrap_up();
      end
      @(posedge pclk);
      irq_req <= '0;
      break_req <= 1'b0;
   endtask
   task automatic take(input siu_row_t t);
      @(posedge pclk);
      irq_req <= t.r;
      irq_en <= t.e;
      break_req <= t.sbmv[2];
      mask_set <= t.sbmv[1];
      mask_clr <= !t.sbmv[1];
      @(posedge pclk);
      mask_set <= 1'b0;
      mask_clr <= 1'b0;
      swi_exec <= t.sbmv[3];
      instr_boundary <= 1'b1;
      @(posedge pclk);
      swi_exec <= 1'b0;
      instr_boundary <= 1'b0;
      #1;
      `CHK("entry valid", t.sbmv[0], entry.valid);
      if (t.sbmv[0]) begin
         `CHK("entry code", t.c, entry.code);
         `CHK("pc minus one", t.p, entry.pc_minus_one);
         `CHK("in break", t.sbmv[2], in_break);
      end
      settle();
   endtask
   // stop, wake by a request, count oscillator falls until the bus runs
   task automatic recover(input logic ssr);
      int n = 0;
      int falls = 0;
      logic prev;
      @(posedge pclk);
      short_stop_recovery <= ssr;
      stop_exec <= 1'b1;
      @(posedge pclk);
      stop_exec <= 1'b0;
      apb(1'b0, SIU_ADDR_RECOV_CNT, 32'h0);
      `CHK("stopped count", 32'h0, rd_data);
      @(posedge pclk);
      irq_req <= 11'h001;
      prev = osc_crystal_clk;
      while (bus_clk_enable !== 1'b1 && n < 40000) begin
         @(posedge pclk);
         falls += int'(prev && !osc_crystal_clk);
         prev = osc_crystal_clk;
         n++;
      end
      if (n >= 40000) begin
         err_total++;
         wrap_up();
      end
      n = ssr ? 32 : 4096;
      `CHK("recovery", 1'b1, falls >= n && falls <= n + 1);
      irq_req <= '0;
   endtask
   // =====================================================
   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, SIU_ADDR_PEND_LOW, 32'h0);
      `CHK("pend low", SIU_PEND_LOW_RST, rd_data);
      irq_req <= 11'h7ff;
      apb(1'b0, SIU_ADDR_PEND_LOW, 32'h0);
      `CHK("pend low", 32'hfc, rd_data);
      apb(1'b1, SIU_ADDR_PEND_LOW, 32'hff);
      apb(1'b0, SIU_ADDR_PEND_LOW, 32'h0);
      `CHK("pend low", 32'hfc, rd_data);
      apb(1'b0, 16'hfe40, 32'h0);
      `CHK("bad address", 1'b1, rd_err);
      irq_req <= '0;
      foreach (rows[k]) take(rows[k]);
      `CHK("clear allow", 1'b0, flag_clear_allow);
      apb(1'b1, SIU_ADDR_BRK_FLAG_CTRL, 32'h1);
      `CHK("clear allow", 1'b1, flag_clear_allow);
      apb(1'b1, SIU_ADDR_BRK_FLAG_CTRL, 32'h0);
      @(posedge pclk);
      break_exit <= 1'b1;
      @(posedge pclk);
      break_exit <= 1'b0;
      #1;
      `CHK("in break", 1'b0, in_break);
      `CHK("clear allow", 1'b1, flag_clear_allow);
      for (int i = 0; i < 11; i++) take({11'(1) << i, 11'h7ff, 4'b0001, 4'(i + 1), 1'b1});
      recover(1'b1);
      recover(1'b0);
      apb(1'b0, SIU_ADDR_RECOV_CNT, 32'h0);
      cnt_before = rd_data;
      ext_reset_pin_n <= 1'b0;
      repeat (6) @(posedge pclk);
      ext_reset_pin_n <= 1'b1;
      #1;
      `CHK("reset code", SIU_CODE_RESET, entry.code);
      settle();
      apb(1'b0, SIU_ADDR_RECOV_CNT, 32'h0);
      `CHK("count kept", 1'b1, 13'(rd_data - cnt_before) < 13'd32);
      wrap_up();
   end
endmodule
`default_nettype wire

// >>> rtl/siu_pkg.sv
// package: constants, register map and carrier types of the system integration unit
`default_nettype none
package siu_pkg;
   // =====================================================
   // register map (byte addresses, 32-bit aligned words)
   localparam logic [15:0] SIU_ADDR_PEND_LOW = 16'hfe04;
   localparam logic [15:0] SIU_ADDR_PEND_HIGH = 16'hfe08;
   localparam logic [15:0] SIU_ADDR_PEND_SPARE = 16'hfe0c;
   localparam logic [15:0] SIU_ADDR_BRK_FLAG_CTRL = 16'hfe10;
   localparam logic [15:0] SIU_ADDR_RECOV_CNT = 16'hfe14;
   localparam logic [7:0] SIU_PEND_LOW_RST = 8'h00;
   localparam logic [7:0] SIU_BFC_RST = 8'h00;
   localparam int SIU_BREAK_CLEAR_ENABLE_BIT = 0;
   localparam int SIU_PEND_LOW_SHIFT = 2;

   // =====================================================
   // interrupt levels and vector codes
   localparam int SIU_NUM_LEVELS = 11;
   localparam int SIU_LOW_TOP = 6;
   localparam logic [3:0] SIU_CODE_SWI = 4'h0;
   localparam logic [3:0] SIU_CODE_RESET = 4'hf;

   // =====================================================
   // recovery counter
   localparam int SIU_CNT_STAGES = 12;
   localparam logic [12:0] SIU_REC_LONG = 13'h1000;
   localparam logic [12:0] SIU_REC_SHORT = 13'h0020;

   typedef enum logic [1:0] {
      SIU_RUN = 2'b00,
      SIU_STOP = 2'b01,
      SIU_RECOVER = 2'b10
   } siu_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } siu_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } siu_apb_rsp_t;

   typedef struct packed {
      logic valid;
      logic [3:0] code;
      logic pc_minus_one;
      logic set_imask;
      logic push_index_high;
   } siu_entry_t;
endpackage
`default_nettype wire

// >>> rtl/siu_top.sv
// system integration unit: recovery counter, exception control, pending status
//
// Operation
// - twelve counting stages then a 13th stage that restarts chain, clocks watchdog
// - counter advances on falling edge of the oscillator crystal clock
// - stop instruction clears the counter so it can time recovery
// - wake samples short recovery option: 32 cycles if set, else 4096
// - external reset pin leaves the counter value unchanged
// - after any reset the counter runs freely and continuously
// - requests latched, arbitrated at entry, constant code selects vector
// - latched request holds until serviced or, for a hardware request, until global mask is cleared
// - entry stacks registers and sets global mask; return restores them
// - interrupt waits for instruction end, needs mask clear and source enabled
// - lowest numbered pending level is serviced first, level 1 highest
// - request pending at return is serviced before next program instruction
// - entry does not stack the high index register
// - software trap interrupts regardless of global mask
// - software trap stacks pc, hardware interrupt stacks pc minus one
// - mask gates all but software trap; sources map to levels 1..11
// - first status register shows levels 6..1 in bits 7..2, bits 1..0 zero
// - flags for levels 11..7 read one while that request is present
// - resets share equal priority above all interrupts, never arbitrated
// - break request enters break state by forcing the trap vector
// - in break, flag clearing blocked unless break clear enable is set
// - flag cleared during break stays cleared after break exits
// - two-step clear first step does not clear while protected
// - after stop wake by interrupt, stacking waits for recovery delay
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module siu_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire siu_pkg::siu_apb_req_t apb_req,
   output siu_pkg::siu_apb_rsp_t apb_rsp,
   input wire logic osc_crystal_clk,
   input wire logic ext_reset_pin_n,
   input wire logic internal_reset,
   input wire logic short_stop_recovery,
   input wire logic stop_exec,
   input wire logic instr_boundary,
   input wire logic global_mask,
   input wire logic swi_exec,
   input wire logic rti_exec,
   input wire logic vector_fetch,
   input wire logic [10:0] irq_req,
   input wire logic [10:0] irq_en,
   input wire logic break_req,
   input wire logic break_exit,
   output siu_pkg::siu_entry_t entry,
   output logic bus_clk_enable,
   output logic watchdog_clk,
   output logic in_break,
   output logic flag_clear_allow
);
   import siu_pkg::*;

   // =====================================================
   // input synchronisers
   logic osc_s1_q;
   logic osc_s2_q;
   logic osc_s3_q;
   logic rstpin_s1_q;
   logic rstpin_s2_q;
   logic osc_fall;

   // two stages for each pin, a third only for edge detection of oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         rstpin_s1_q <= 1'b1;
         rstpin_s2_q <= 1'b1;
      end else begin
         osc_s1_q <= osc_crystal_clk;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         rstpin_s1_q <= ext_reset_pin_n;
         rstpin_s2_q <= rstpin_s1_q;
      end
   end

   assign osc_fall = osc_s3_q & ~osc_s2_q;

   // =====================================================
   // mode control: run, stop, recovery
   siu_mode_t mode_q;
   siu_mode_t mode_d;
   logic [12:0] cnt_q;
   logic [12:0] rec_target_q;
   logic wake;
   logic rec_done;
   logic [10:0] pend;

   assign pend = irq_req & irq_en;
   assign wake = (|pend) | break_req | ~rstpin_s2_q | internal_reset;
   // last of the selected number of oscillator falls ends recovery
   assign rec_done = osc_fall && (cnt_q == rec_target_q - 13'h0001);

   // next mode
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         SIU_RUN: begin
            if (stop_exec) begin
               mode_d = SIU_STOP;
            end
         end
         SIU_STOP: begin
            if (wake) begin
               mode_d = SIU_RECOVER;
            end
         end
         SIU_RECOVER: begin
            if (rec_done) begin
               mode_d = SIU_RUN;
            end
         end
         default: begin
            mode_d = SIU_RUN;
         end
      endcase
   end

   // mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= SIU_RUN;
      end else begin
         mode_q <= mode_d;
      end
   end

   // recovery length chosen when stop is left
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_target_q <= SIU_REC_LONG;
      end else if (mode_q == SIU_STOP && wake) begin
         rec_target_q <= short_stop_recovery ? SIU_REC_SHORT : SIU_REC_LONG;
      end
   end

   // =====================================================
   // recovery counter
   // low 12 bits count, bit 12 is the 13th stage toggled by their overflow
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (internal_reset || mode_q == SIU_STOP || stop_exec) begin
         cnt_q <= '0;
      end else if (osc_fall) begin
         cnt_q <= cnt_q + 13'h0001;
      end
   end

   assign watchdog_clk = cnt_q[SIU_CNT_STAGES];
   assign bus_clk_enable = (mode_q == SIU_RUN);

   // =====================================================
   // exception control: latch and arbitration
   logic latched_q;
   logic [3:0] latched_code_q;
   logic latched_hw_q;
   logic [3:0] arb_code;
   logic arb_any;
   logic mask_prev_q;
   logic mask_fall;
   logic boundary_ok;

   // lowest numbered enabled pending level wins
   always_comb begin
      arb_code = SIU_CODE_SWI;
      arb_any = 1'b0;
      for (int i = SIU_NUM_LEVELS - 1; i >= 0; i--) begin
         if (pend[i]) begin
            arb_code = 4'(i + 1);
            arb_any = 1'b1;
         end
      end
   end

   assign mask_fall = mask_prev_q & ~global_mask;
   assign boundary_ok = instr_boundary && (mode_q == SIU_RUN);

   // global mask history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_prev_q <= 1'b1;
      end else begin
         mask_prev_q <= global_mask;
      end
   end

   // latch holds one request until its vector is fetched or, for a hardware request, the global mask falls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latched_q <= 1'b0;
         latched_code_q <= SIU_CODE_SWI;
         latched_hw_q <= 1'b0;
      end else if (internal_reset || !rstpin_s2_q) begin
         latched_q <= 1'b1;
         latched_code_q <= SIU_CODE_RESET;
         latched_hw_q <= 1'b0;
      end else if (latched_q) begin
         if (vector_fetch || (mask_fall && latched_hw_q)) begin
            latched_q <= 1'b0;
         end
      end else if (boundary_ok) begin
         if (swi_exec || break_req) begin
            latched_q <= 1'b1;
            latched_code_q <= SIU_CODE_SWI;
            latched_hw_q <= 1'b0;
         end else if (!global_mask && arb_any) begin
            latched_q <= 1'b1;
            latched_code_q <= arb_code;
            latched_hw_q <= 1'b1;
         end
      end
   end

   // entry request toward the core
   always_comb begin
      entry.valid = latched_q;
      entry.code = latched_code_q;
      entry.pc_minus_one = latched_hw_q;
      entry.set_imask = latched_q && (latched_code_q != SIU_CODE_RESET);
      entry.push_index_high = 1'b0;
   end

   // =====================================================
   // break state and flag protection
   logic in_break_q;
   logic [7:0] bfc_q;

   // break entered by forced trap, left on break exit or return
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_break_q <= 1'b0;
      end else if (boundary_ok && !latched_q && break_req) begin
         in_break_q <= 1'b1;
      end else if (break_exit || rti_exec) begin
         in_break_q <= 1'b0;
      end
   end

   assign in_break = in_break_q;
   // clear steps in other modules are honoured only when allowed
   assign flag_clear_allow = ~in_break_q | bfc_q[SIU_BREAK_CLEAR_ENABLE_BIT];

   // =====================================================
   // apb slave
   logic acc;
   logic hit_low;
   logic hit_high;
   logic hit_spare;
   logic hit_bfc;
   logic hit_cnt;
   logic [7:0] pend_low;
   logic [7:0] pend_high;

   assign acc = apb_req.psel & apb_req.penable;
   assign hit_low = (apb_req.paddr == SIU_ADDR_PEND_LOW);
   assign hit_high = (apb_req.paddr == SIU_ADDR_PEND_HIGH);
   assign hit_spare = (apb_req.paddr == SIU_ADDR_PEND_SPARE);
   assign hit_bfc = (apb_req.paddr == SIU_ADDR_BRK_FLAG_CTRL);
   assign hit_cnt = (apb_req.paddr == SIU_ADDR_RECOV_CNT);
   assign pend_low = {irq_req[SIU_LOW_TOP-1:0], 2'b00};
   assign pend_high = {3'b000, irq_req[SIU_NUM_LEVELS-1:SIU_LOW_TOP]};

   // only the break flag control register is writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bfc_q <= SIU_BFC_RST;
      end else if (acc && apb_req.pwrite && hit_bfc) begin
         bfc_q <= {7'h00, apb_req.pwdata[SIU_BREAK_CLEAR_ENABLE_BIT]};
      end
   end

   // read data and error, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp.prdata <= 32'h0000_0000;
      end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         if (hit_low) begin
            apb_rsp.prdata <= {24'h000000, pend_low};
         end else if (hit_high) begin
            apb_rsp.prdata <= {24'h000000, pend_high};
         end else if (hit_bfc) begin
            apb_rsp.prdata <= {24'h000000, bfc_q};
         end else if (hit_cnt) begin
            apb_rsp.prdata <= {19'h00000, cnt_q};
         end else begin
            apb_rsp.prdata <= 32'h0000_0000; // spare reads zero
         end
      end
   end

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = acc & ~(hit_low | hit_high | hit_spare | hit_bfc | hit_cnt);
endmodule
`default_nettype wire
